/* common/sbc_store_pkg.sv */
package cpu_ops_pkg;

  // instruction groups handled by the core
  typedef enum logic [3:0] {
    op_none, op_subtract, op_set_carry, op_set_decimal, op_set_mask, op_store_acc,
    op_store_x, op_store_y, op_copy_a_x, op_copy_a_y, op_copy_s_x, op_copy_x_a,
    op_copy_x_s, op_copy_y_a, op_return
  } op_type;

  // addressing modes
  typedef enum logic [3:0] {
    m_impl, m_imm, m_zp, m_zpx, m_zpy, m_abs, m_absx, m_absy, m_indx, m_indy
  } mode_type;

  // subtract_with_borrow encodings
  localparam logic [7:0] OPC_SUB_IMM = 8'he9;
  localparam logic [7:0] OPC_SUB_ZP = 8'he5;
  localparam logic [7:0] OPC_SUB_ZPX = 8'hf5;
  localparam logic [7:0] OPC_SUB_ABS = 8'hed;
  localparam logic [7:0] OPC_SUB_ABSX = 8'hfd;
  localparam logic [7:0] OPC_SUB_ABSY = 8'hf9;
  localparam logic [7:0] OPC_SUB_INDX = 8'he1;
  localparam logic [7:0] OPC_SUB_INDY = 8'hf1;
  // flag set encodings
  localparam logic [7:0] OPC_SET_CARRY = 8'h38;
  localparam logic [7:0] OPC_SET_DEC = 8'hf8;
  localparam logic [7:0] OPC_SET_MASK = 8'h78;
  // store encodings
  localparam logic [7:0] OPC_ST_ACC_ZP = 8'h85;
  localparam logic [7:0] OPC_ST_ACC_ZPX = 8'h95;
  localparam logic [7:0] OPC_ST_ACC_ABS = 8'h8d;
  localparam logic [7:0] OPC_ST_ACC_ABSX = 8'h9d;
  localparam logic [7:0] OPC_ST_ACC_ABSY = 8'h99;
  localparam logic [7:0] OPC_ST_ACC_INDX = 8'h81;
  localparam logic [7:0] OPC_ST_ACC_INDY = 8'h91;
  localparam logic [7:0] OPC_ST_X_ZP = 8'h86;
  localparam logic [7:0] OPC_ST_X_ZPY = 8'h96;
  localparam logic [7:0] OPC_ST_X_ABS = 8'h8e;
  localparam logic [7:0] OPC_ST_Y_ZP = 8'h84;
  localparam logic [7:0] OPC_ST_Y_ZPX = 8'h94;
  localparam logic [7:0] OPC_ST_Y_ABS = 8'h8c;
  // transfer and return encodings
  localparam logic [7:0] OPC_COPY_A_X = 8'haa;
  localparam logic [7:0] OPC_COPY_A_Y = 8'ha8;
  localparam logic [7:0] OPC_COPY_S_X = 8'hba;
  localparam logic [7:0] OPC_COPY_X_A = 8'h8a;
  localparam logic [7:0] OPC_COPY_X_S = 8'h9a;
  localparam logic [7:0] OPC_COPY_Y_A = 8'h98;
  localparam logic [7:0] OPC_RETURN = 8'h60;

  // values after reset, stack and zero page numbers
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_SP = 8'hff;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  // return sequence steps after the dummy stack read
  localparam logic [1:0] RTS_LAST_STEP = 2'h3;

endpackage

/* rtl/op_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

module op_decoder
  import cpu_ops_pkg::*;
(
  // instruction byte
  input wire logic [7:0] opcode,
  // decoded class
  output op_type op,
  output mode_type mode,
  output logic is_store
);

  // opcode to operation and addressing mode
  always_comb begin
    op = op_none;
    mode = m_impl;
    case (opcode)
      OPC_SUB_IMM: begin op = op_subtract; mode = m_imm; end
      OPC_SUB_ZP: begin op = op_subtract; mode = m_zp; end
      OPC_SUB_ZPX: begin op = op_subtract; mode = m_zpx; end
      OPC_SUB_ABS: begin op = op_subtract; mode = m_abs; end
      OPC_SUB_ABSX: begin op = op_subtract; mode = m_absx; end
      OPC_SUB_ABSY: begin op = op_subtract; mode = m_absy; end
      OPC_SUB_INDX: begin op = op_subtract; mode = m_indx; end
      OPC_SUB_INDY: begin op = op_subtract; mode = m_indy; end
      OPC_SET_CARRY: op = op_set_carry;
      OPC_SET_DEC: op = op_set_decimal;
      OPC_SET_MASK: op = op_set_mask;
      OPC_ST_ACC_ZP: begin op = op_store_acc; mode = m_zp; end
      OPC_ST_ACC_ZPX: begin op = op_store_acc; mode = m_zpx; end
      OPC_ST_ACC_ABS: begin op = op_store_acc; mode = m_abs; end
      OPC_ST_ACC_ABSX: begin op = op_store_acc; mode = m_absx; end
      OPC_ST_ACC_ABSY: begin op = op_store_acc; mode = m_absy; end
      OPC_ST_ACC_INDX: begin op = op_store_acc; mode = m_indx; end
      OPC_ST_ACC_INDY: begin op = op_store_acc; mode = m_indy; end
      OPC_ST_X_ZP: begin op = op_store_x; mode = m_zp; end
      OPC_ST_X_ZPY: begin op = op_store_x; mode = m_zpy; end
      OPC_ST_X_ABS: begin op = op_store_x; mode = m_abs; end
      OPC_ST_Y_ZP: begin op = op_store_y; mode = m_zp; end
      OPC_ST_Y_ZPX: begin op = op_store_y; mode = m_zpx; end
      OPC_ST_Y_ABS: begin op = op_store_y; mode = m_abs; end
      OPC_COPY_A_X: op = op_copy_a_x;
      OPC_COPY_A_Y: op = op_copy_a_y;
      OPC_COPY_S_X: op = op_copy_s_x;
      OPC_COPY_X_A: op = op_copy_x_a;
      OPC_COPY_X_S: op = op_copy_x_s;
      OPC_COPY_Y_A: op = op_copy_y_a;
      OPC_RETURN: op = op_return;
      // anything else runs as a two-cycle no-op
      default: op = op_none;
    endcase
  end

  // stores write instead of read in their data cycle
  assign is_store = (op == op_store_acc) || (op == op_store_x) || (op == op_store_y);

endmodule

`default_nettype wire

/* rtl/sbc_alu.sv */
`timescale 1ns/1ps
`default_nettype none

module borrow_alu (
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic decimal,
  // results
  output logic [7:0] result,
  output logic carry_out,
  output logic overflow,
  output logic negative,
  output logic zero
);

  logic [8:0] bin_sum; // binary difference with carry out
  logic [4:0] lo_diff; // low digit difference
  logic [4:0] hi_diff; // high digit difference
  logic [3:0] lo_adj; // corrected low digit
  logic [3:0] hi_adj; // corrected high digit

  // binary subtract as add of the complement, carry clear means borrow
  assign bin_sum = {1'b0, acc} + {1'b0, ~operand} + {8'h00, carry_in};
  assign carry_out = bin_sum[8];
  assign overflow = (acc[7] ^ operand[7]) & (acc[7] ^ bin_sum[7]);
  // flags follow the binary result, also in decimal mode
  assign negative = bin_sum[7];
  assign zero = (bin_sum[7:0] == 8'h00);

  // packed decimal: subtract per digit and take six off a digit that borrowed
  always_comb begin
    lo_diff = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, ~carry_in};
    lo_adj = lo_diff[4] ? (lo_diff[3:0] - 4'h6) : lo_diff[3:0];
    hi_diff = {1'b0, acc[7:4]} - {1'b0, operand[7:4]} - {4'h0, lo_diff[4]};
    hi_adj = hi_diff[4] ? (hi_diff[3:0] - 4'h6) : hi_diff[3:0];
    result = decimal ? {hi_adj, lo_adj} : bin_sum[7:0];
  end

endmodule

`default_nettype wire

/* rtl/sbc_store_core.sv */
// Function
// - subtract operand and borrow from accumulator
// - decode absolute, indexed and indirect subtract forms
// - subtract cycle counts, page cross adds one
// - three implied opcodes set carry, decimal, mask
// - store accumulator, fixed cycle counts, no adjustment
// - store index x in three modes
// - store index y in three modes
// - copy accumulator to x, two cycles
// - copy accumulator to y, two cycles
// - copy stack pointer to x, two cycles
// - copy x to accumulator, two cycles
// - copy x to stack pointer, two cycles
// - copy y to accumulator, two cycles
// - return pulls pc, adds one, six cycles
`timescale 1ns/1ps
`default_nettype none

module cpu_store_transfer_subtract_ops
  import cpu_ops_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // memory bus
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic we,
  input wire logic [7:0] rdata,
  // status
  output logic sync,
  output logic [15:0] pc,
  output logic [7:0] acc,
  output logic [7:0] xreg,
  output logic [7:0] yreg,
  output logic [7:0] sp,
  output logic [7:0] flags
);

  // one state per processor cycle kind
  typedef enum logic [3:0] {
    st_fetch, st_op1, st_op2, st_zpidx, st_ptr_lo, st_ptr_hi, st_fix, st_data, st_rts
  } state_type;

  state_type state, next_state; // cycle sequencer
  logic [7:0] ir, next_ir; // latched opcode
  logic [15:0] next_pc; // program counter
  logic [15:0] ea, next_ea; // effective address
  logic [7:0] tmp, next_tmp; // pointer or pulled low byte
  logic fix_carry, next_fix_carry; // high byte needs increment
  logic [1:0] step, next_step; // return sequence step
  logic [7:0] next_acc, next_xreg, next_yreg, next_sp; // user registers
  logic fn, fz, fc, fi, fd, fv; // processor flags
  logic next_fn, next_fz, next_fc, next_fi, next_fd, next_fv;
  op_type op; // decoded operation
  mode_type mode; // decoded addressing mode
  logic is_store; // store instruction
  logic [8:0] idx_sum; // low byte plus index
  logic [7:0] index; // index for the current mode
  logic do_sub; // subtract executes this cycle
  logic [7:0] sub_res; // subtract result
  logic sub_c, sub_v, sub_n, sub_z; // subtract flags

  // negative and zero of a byte
  function automatic logic [1:0] nz_of(input logic [7:0] v);
    nz_of = {v[7], v == 8'h00};
  endfunction

  // decoder of the latched opcode
  op_decoder u_dec (
    .opcode(ir),
    .op(op),
    .mode(mode),
    .is_store(is_store)
  );

  // subtract datapath
  borrow_alu u_alu (
    .acc(acc),
    .operand(rdata),
    .carry_in(fc),
    .decimal(fd),
    .result(sub_res),
    .carry_out(sub_c),
    .overflow(sub_v),
    .negative(sub_n),
    .zero(sub_z)
  );

  // y indexes y-modes, x the rest
  assign index = (mode == m_zpy || mode == m_absy || mode == m_indy) ? yreg : xreg;
  assign idx_sum = (state == st_ptr_hi) ? ({1'b0, tmp} + {1'b0, yreg})
                                         : ({1'b0, ea[7:0]} + {1'b0, index});
  // subtract runs on the operand cycle for immediate, else the data cycle
  assign do_sub = (op == op_subtract)
                  && ((state == st_op1 && mode == m_imm) || state == st_data);
  assign sync = (state == st_fetch);
  assign flags = {fn, fv, 1'b1, 1'b0, fd, fi, fz, fc};

  // bus address and write strobe per cycle
  always_comb begin
    addr = pc;
    we = 1'b0;
    wdata = 8'h00;
    case (state)
      st_zpidx, st_ptr_lo, st_ptr_hi, st_fix: addr = ea; // dummy or pointer reads
      st_data: begin
        addr = ea;
        we = is_store;
        // only stores reach here with a write
        if (op == op_store_x) begin
          wdata = xreg;
        end else if (op == op_store_y) begin
          wdata = yreg;
        end else begin
          wdata = acc;
        end
      end
      st_rts: addr = (step == RTS_LAST_STEP) ? pc : {STACK_PAGE, sp};
      default: addr = pc;
    endcase
  end

  // next state of sequencer and registers
  always_comb begin
    next_state = state;
    next_ir = ir;
    next_pc = pc;
    next_ea = ea;
    next_tmp = tmp;
    next_fix_carry = fix_carry;
    next_step = step;
    next_acc = acc;
    next_xreg = xreg;
    next_yreg = yreg;
    next_sp = sp;
    {next_fn, next_fz, next_fc, next_fi, next_fd, next_fv} = {fn, fz, fc, fi, fd, fv};
    case (state)
      // opcode fetch
      st_fetch: begin
        next_ir = rdata;
        next_pc = pc + 16'h0001;
        next_state = st_op1;
      end
      // second byte, or the implied instruction's spare cycle
      st_op1: begin
        next_state = st_fetch;
        if (mode != m_impl) begin
          next_pc = pc + 16'h0001;
          next_ea = {ZERO_PAGE, rdata};
        end
        case (mode)
          m_impl: begin
            case (op)
              op_set_carry: next_fc = 1'b1;
              op_set_decimal: next_fd = 1'b1;
              op_set_mask: next_fi = 1'b1;
              op_copy_a_x: begin
                next_xreg = acc;
                {next_fn, next_fz} = nz_of(acc);
              end
              op_copy_a_y: begin
                next_yreg = acc;
                {next_fn, next_fz} = nz_of(acc);
              end
              op_copy_s_x: begin
                next_xreg = sp;
                {next_fn, next_fz} = nz_of(sp);
              end
              op_copy_x_a: begin
                next_acc = xreg;
                {next_fn, next_fz} = nz_of(xreg);
              end
              op_copy_x_s: next_sp = xreg;
              op_copy_y_a: begin
                next_acc = yreg;
                {next_fn, next_fz} = nz_of(yreg);
              end
              op_return: begin
                next_state = st_rts;
                next_step = 2'h0;
              end
              default: next_state = st_fetch;
            endcase
          end
          m_imm: next_state = st_fetch;
          m_zp: next_state = st_data;
          m_zpx, m_zpy, m_indx: next_state = st_zpidx;
          m_indy: next_state = st_ptr_lo;
          default: begin
            // absolute forms take a third byte
            next_ea = {8'h00, rdata};
            next_state = st_op2;
          end
        endcase
      end
      // high address byte, index added to the low byte in the indexed absolute forms
      st_op2: begin
        next_pc = pc + 16'h0001;
        if (mode == m_abs) begin
          next_ea = {rdata, ea[7:0]};
          next_state = st_data;
        end else begin
          next_ea = {rdata, idx_sum[7:0]};
          next_fix_carry = idx_sum[8];
          // reads skip the fix cycle unless the page is crossed
          next_state = (idx_sum[8] || is_store) ? st_fix : st_data;
        end
      end
      // zero page index add, wraps within page zero
      st_zpidx: begin
        next_ea = {ZERO_PAGE, idx_sum[7:0]};
        next_state = (mode == m_indx) ? st_ptr_lo : st_data;
      end
      // pointer low byte
      st_ptr_lo: begin
        next_tmp = rdata;
        next_ea = {ZERO_PAGE, ea[7:0] + 8'h01};
        next_state = st_ptr_hi;
      end
      // pointer high byte, post-index for indirect-indexed
      st_ptr_hi: begin
        if (mode == m_indx) begin
          next_ea = {rdata, tmp};
          next_state = st_data;
        end else begin
          next_ea = {rdata, idx_sum[7:0]};
          next_fix_carry = idx_sum[8];
          next_state = (idx_sum[8] || is_store) ? st_fix : st_data;
        end
      end
      // page correction cycle
      st_fix: begin
        next_ea = {ea[15:8] + {7'h00, fix_carry}, ea[7:0]};
        next_state = st_data;
      end
      // operand read or store write
      st_data: next_state = st_fetch;
      // return: stack dummy, pull low, pull high, increment
      st_rts: begin
        next_step = step + 2'h1;
        case (step)
          2'h0: next_sp = sp + 8'h01;
          2'h1: begin
            next_tmp = rdata;
            next_sp = sp + 8'h01;
          end
          2'h2: next_pc = {rdata, tmp};
          default: begin
            next_pc = pc + 16'h0001;
            next_state = st_fetch;
          end
        endcase
      end
      default: next_state = st_fetch;
    endcase
    // subtract write-back and flags
    if (do_sub) begin
      next_acc = sub_res;
      {next_fn, next_fz, next_fc, next_fv} = {sub_n, sub_z, sub_c, sub_v};
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= st_fetch;
      ir <= RESET_REG;
      pc <= RESET_PC;
      ea <= 16'h0000;
      tmp <= RESET_REG;
      fix_carry <= 1'b0;
      step <= 2'h0;
      acc <= RESET_REG;
      xreg <= RESET_REG;
      yreg <= RESET_REG;
      sp <= RESET_SP;
      {fn, fz, fc, fi, fd, fv} <= 6'h04;
    end else begin
      state <= next_state;
      ir <= next_ir;
      pc <= next_pc;
      ea <= next_ea;
      tmp <= next_tmp;
      fix_carry <= next_fix_carry;
      step <= next_step;
      acc <= next_acc;
      xreg <= next_xreg;
      yreg <= next_yreg;
      sp <= next_sp;
      {fn, fz, fc, fi, fd, fv} <= {next_fn, next_fz, next_fc, next_fi, next_fd, next_fv};
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_fetch_of(logic [7:0] code);
    sync && rdata == code;
  endsequence

  a_sub_binary_result: assert property (
    (do_sub && !fd) |=> acc == 8'($past(acc) - $past(rdata) - {7'h00, !$past(fc)}))
    else $error("subtract result wrong");
  a_sub_imm_two: assert property (seq_fetch_of(OPC_SUB_IMM) |-> ##2 sync)
    else $error("immediate subtract not two cycles");
  a_sub_indx_six: assert property (
    seq_fetch_of(OPC_SUB_INDX) |-> ##1 !sync [*5] ##1 sync)
    else $error("indexed-indirect subtract not six cycles");
  a_store_abs_write: assert property (
    seq_fetch_of(OPC_ST_ACC_ABS) |-> ##1 !we [*2] ##1 (we && wdata == acc) ##1 sync)
    else $error("absolute store timing wrong");
  a_store_keeps_flags: assert property (we |=> $stable(flags))
    else $error("store changed flags");
  a_flag_set_ops: assert property (
    (state == st_op1 && (op == op_set_carry || op == op_set_decimal || op == op_set_mask))
      |=> (fc || op != op_set_carry) && (fd || op != op_set_decimal)
          && (fi || op != op_set_mask))
    else $error("flag set failed");
  a_copy_to_x: assert property (
    (state == st_op1 && op == op_copy_a_x) |=> xreg == $past(acc) && fz == (xreg == 8'h00))
    else $error("copy to x wrong");
  a_copy_to_sp: assert property (
    (state == st_op1 && op == op_copy_x_s) |=> sp == $past(xreg) && $stable(flags) && sync)
    else $error("copy to stack pointer wrong");
  a_return_six: assert property (
    seq_fetch_of(OPC_RETURN) |-> ##1 !sync [*5] ##1 sync)
    else $error("return not six cycles");

endmodule

`default_nettype wire

/* testbench/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far-side memory: combinational read, write at the end of a we cycle
module mem_model (
  // clock
  input wire logic clk,
  // bus from the core
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  output logic [7:0] rdata
);
  // whole 64k space, loaded by the bench
  logic [7:0] mem [0:65535];

  // answer in the same cycle as the address
  assign rdata = mem[addr];

  // store lands on the edge that closes the write cycle
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule

`default_nettype wire

/* testbench/test_sbc_store_core.sv */
`timescale 1ns/1ps
`default_nettype none

module test_cpu_store_transfer_subtract_ops
  import cpu_ops_pkg::*;
;
  // clock, reset and bus
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] addr, pc;
  logic [7:0] wdata, rdata, acc, xreg, yreg, sp, flags;
  logic we, sync;
  // counters
  int failures = 0;
  int total_checks = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  cpu_store_transfer_subtract_ops cpu_store_transfer_subtract_ops_i (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .rdata(rdata),
    .sync(sync), .pc(pc), .acc(acc), .xreg(xreg), .yreg(yreg), .sp(sp), .flags(flags)
  );
  mem_model mem_model_i (.clk(clk), .addr(addr), .wdata(wdata), .we(we), .rdata(rdata));

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts, verdict, end of run
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // fill with no-ops, load code at 0000, reset for 5 cycles
  task automatic boot(input logic [7:0] code[$]);
    for (int i = 0; i < 65536; i++) begin
      mem_model_i.mem[i] = 8'hea;
    end
    foreach (code[i]) begin
      mem_model_i.mem[i] = code[i];
    end
    srst = 1'b1;
    repeat (5) @(negedge clk);
    srst = 1'b0;
  endtask

  // data byte for a later operand read
  task automatic poke(input logic [15:0] a, input logic [7:0] v);
    mem_model_i.mem[a] = v;
  endtask

  // one instruction, fetch to next fetch, then the user registers
  task automatic step(input int cyc, input logic [7:0] ea, input logic [7:0] ex,
                      input logic [7:0] ey, input logic [7:0] es, input logic [7:0] ef);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sync !== 1'b1 && n < 20);
    // hung instruction ends the run
    if (n >= 20) begin
      failures++;
      results();
    end
    check("cycles", 16'(n), 16'(cyc));
    check("acc", 16'(acc), 16'(ea));
    check("xreg", 16'(xreg), 16'(ex));
    check("yreg", 16'(yreg), 16'(ey));
    check("sp", 16'(sp), 16'(es));
    check("flags", 16'(flags), 16'(ef));
  endtask

  // state right after reset release
  task automatic sc_reset();
    boot('{8'hea});
    check("addr", addr, 16'h0000);
    check("sync", 16'(sync), 16'h0001);
    check("we", 16'(we), 16'h0000);
    check("pc", pc, 16'h0000);
    check("sp", 16'(sp), 16'h00ff);
    check("flags", 16'(flags), 16'h0024);
  endtask

  // borrow, overflow, zero, copies and flag sets
  task automatic sc_arith();
    boot('{8'h38, 8'hba, 8'h8a, 8'he9, 8'h10, 8'he9, 8'hef, 8'he9, 8'h01, 8'he9, 8'h00,
           8'he5, 8'h40, 8'haa, 8'h98, 8'h9a, 8'h8a, 8'ha8, 8'hf8, 8'h78});
    poke(16'h0040, 8'h7f);
    step(2, 8'h00, 8'h00, 8'h00, 8'hff, 8'h25);
    step(2, 8'h00, 8'hff, 8'h00, 8'hff, 8'ha5);
    step(2, 8'hff, 8'hff, 8'h00, 8'hff, 8'ha5);
    step(2, 8'hef, 8'hff, 8'h00, 8'hff, 8'ha5);
    step(2, 8'h00, 8'hff, 8'h00, 8'hff, 8'h27);
    step(2, 8'hff, 8'hff, 8'h00, 8'hff, 8'ha4);
    step(2, 8'hfe, 8'hff, 8'h00, 8'hff, 8'ha5);
    step(3, 8'h7f, 8'hff, 8'h00, 8'hff, 8'h65);
    step(2, 8'h7f, 8'h7f, 8'h00, 8'hff, 8'h65);
    step(2, 8'h00, 8'h7f, 8'h00, 8'hff, 8'h67);
    step(2, 8'h00, 8'h7f, 8'h00, 8'h7f, 8'h67);
    step(2, 8'h7f, 8'h7f, 8'h00, 8'h7f, 8'h65);
    step(2, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h65);
    step(2, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h6d);
    step(2, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h6d);
  endtask

  // memory forms of subtract, with and without page crossing
  task automatic sc_modes();
    boot('{8'h38, 8'hed, 8'h00, 8'h30, 8'ha8, 8'hba, 8'hfd, 8'h34, 8'h12, 8'hf9, 8'h00,
           8'h12, 8'hf5, 8'h80, 8'he1, 8'h81, 8'hf1, 8'h82, 8'hf1, 8'h84});
    poke(16'h3000, 8'h01);
    poke(16'h1333, 8'h0e);
    poke(16'h12ff, 8'h10);
    poke(16'h007f, 8'h20);
    poke(16'h0081, 8'h31);
    poke(16'h0082, 8'h01);
    poke(16'h0083, 8'h31);
    poke(16'h0085, 8'h32);
    poke(16'h0080, 8'h00);
    poke(16'h0084, 8'h00);
    poke(16'h3100, 8'h40);
    poke(16'h3200, 8'h80);
    poke(16'h32ff, 8'h01);
    step(2, 8'h00, 8'h00, 8'h00, 8'hff, 8'h25);
    step(4, 8'hff, 8'h00, 8'h00, 8'hff, 8'ha4);
    step(2, 8'hff, 8'h00, 8'hff, 8'hff, 8'ha4);
    step(2, 8'hff, 8'hff, 8'hff, 8'hff, 8'ha4);
    step(5, 8'hf0, 8'hff, 8'hff, 8'hff, 8'ha5);
    step(4, 8'he0, 8'hff, 8'hff, 8'hff, 8'ha5);
    step(4, 8'hc0, 8'hff, 8'hff, 8'hff, 8'ha5);
    step(6, 8'h80, 8'hff, 8'hff, 8'hff, 8'ha5);
    step(6, 8'h00, 8'hff, 8'hff, 8'hff, 8'h27);
    step(5, 8'hff, 8'hff, 8'hff, 8'hff, 8'ha4);
  endtask

  // every store form, no flag change, no page-cross cycle
  task automatic sc_store();
    int cy [13] = '{3, 4, 4, 5, 5, 6, 6, 3, 4, 4, 3, 4, 4};
    logic [15:0] wa [13] = '{16'h00a0, 16'h00af, 16'h2000, 16'h2100, 16'h21f0, 16'h2200,
                             16'h2310, 16'h0050, 16'h0060, 16'h2400, 16'h0051, 16'h0061,
                             16'h2401};
    boot('{8'hba, 8'h8a, 8'h38, 8'he9, 8'h0f, 8'ha8, 8'he9, 8'h10, 8'h85, 8'ha0,
           8'h95, 8'hb0, 8'h8d, 8'h00, 8'h20, 8'h9d, 8'h01, 8'h20, 8'h99, 8'h00, 8'h21,
           8'h81, 8'h40, 8'h91, 8'h42, 8'h86, 8'h50, 8'h96, 8'h70, 8'h8e, 8'h00, 8'h24,
           8'h84, 8'h51, 8'h94, 8'h62, 8'h8c, 8'h01, 8'h24});
    poke(16'h003f, 8'h00);
    poke(16'h0040, 8'h22);
    poke(16'h0042, 8'h20);
    poke(16'h0043, 8'h22);
    step(2, 8'h00, 8'hff, 8'h00, 8'hff, 8'ha4);
    step(2, 8'hff, 8'hff, 8'h00, 8'hff, 8'ha4);
    step(2, 8'hff, 8'hff, 8'h00, 8'hff, 8'ha5);
    step(2, 8'hf0, 8'hff, 8'h00, 8'hff, 8'ha5);
    step(2, 8'hf0, 8'hff, 8'hf0, 8'hff, 8'ha5);
    step(2, 8'he0, 8'hff, 8'hf0, 8'hff, 8'ha5);
    foreach (cy[i]) begin
      step(cy[i], 8'he0, 8'hff, 8'hf0, 8'hff, 8'ha5);
    end
    // first seven hold acc, next three x, last three y
    foreach (wa[i]) begin
      check("mem", 16'(mem_model_i.mem[wa[i]]),
            (i < 7) ? 16'h00e0 : (i < 10) ? 16'h00ff : 16'h00f0);
    end
  endtask

  // packed decimal subtract with and without borrow
  task automatic sc_decimal();
    boot('{8'h38, 8'he9, 8'hb8, 8'h38, 8'hf8, 8'he9, 8'h15, 8'he9, 8'h34, 8'he9, 8'h00});
    step(2, 8'h00, 8'h00, 8'h00, 8'hff, 8'h25);
    step(2, 8'h48, 8'h00, 8'h00, 8'hff, 8'h24);
    step(2, 8'h48, 8'h00, 8'h00, 8'hff, 8'h25);
    step(2, 8'h48, 8'h00, 8'h00, 8'hff, 8'h2d);
    step(2, 8'h33, 8'h00, 8'h00, 8'hff, 8'h2d);
    step(2, 8'h99, 8'h00, 8'h00, 8'hff, 8'hac);
    step(2, 8'h98, 8'h00, 8'h00, 8'hff, 8'had);
  endtask

  // return pulls the address, adds one, takes six cycles
  task automatic sc_return();
    boot('{8'h38, 8'he9, 8'h03, 8'haa, 8'h9a, 8'h60});
    poke(16'h01fe, 8'hff);
    poke(16'h01ff, 8'h0f);
    step(2, 8'h00, 8'h00, 8'h00, 8'hff, 8'h25);
    step(2, 8'hfd, 8'h00, 8'h00, 8'hff, 8'ha4);
    step(2, 8'hfd, 8'hfd, 8'h00, 8'hff, 8'ha4);
    step(2, 8'hfd, 8'hfd, 8'h00, 8'hfd, 8'ha4);
    step(6, 8'hfd, 8'hfd, 8'h00, 8'hff, 8'ha4);
    check("addr", addr, 16'h1000);
  endtask

  // main sequence
  initial begin
    sc_reset();
    sc_arith();
    sc_modes();
    sc_store();
    sc_decimal();
    sc_return();
    results();
  end
endmodule

`default_nettype wire
